// *** src/txp_pkg.sv ***
/*
 * constants, field positions and types shared by both ends of the
 * transmit command/data path.
 * assumes both ends run on one clock (mclk) with reset rst_n.
 */
// How it works
// (RULE_01) each buffer starts with two command words
// (RULE_02) host writes word A, word B, then data
// (RULE_03) packet bounds come only from command bits
// (RULE_04) both command words sent for every buffer
// (RULE_05) tag of word B copied into status
// (RULE_06) differing word B within packet raises error
// (RULE_07) counted bytes must equal packet length
// (RULE_08) start offset skips bytes, first eight doublewords
// (RULE_09) later buffers may start on any byte
// (RULE_10) padding up to end alignment is dropped
// (RULE_11) completion request raises event when buffer loaded
// (RULE_12) status word pushed after every packet sent; the code drops it when the status fifo is full
// (RULE_13) status level event at programmed count
// (RULE_14) host reads free space before writing
// (RULE_15) overfilling the data fifo raises error
// (RULE_16) host writes 16-bit halves, paired into words
// (RULE_17) word A bit 31 requests completion flag
// (RULE_18) word A bits 25:24 select end alignment
// (RULE_19) host writes zero to word A bits 30:26
// (RULE_20) first buffer word B latched for comparison
// (RULE_21) reserved alignment code is a command error
package txp_pkg;
    // command word A
    localparam int TXP_A_IOC      = 31;
    localparam int TXP_A_RSV_HI   = 30;
    localparam int TXP_A_RSV_LO   = 26;
    localparam int TXP_A_ALN_HI   = 25;
    localparam int TXP_A_ALN_LO   = 24;
    localparam int TXP_A_OFF_HI   = 20;
    localparam int TXP_A_OFF_LO   = 16;
    localparam int TXP_A_FIRST    = 13;
    localparam int TXP_A_LAST     = 12;
    localparam int TXP_A_SIZE_HI  = 10;
    // command word B
    localparam int TXP_B_TAG_HI   = 31;
    localparam int TXP_B_TAG_LO   = 16;
    localparam int TXP_B_LEN_HI   = 10;
    // widths
    localparam int TXP_LEN_W      = 11;
    localparam int TXP_TAG_W      = 16;
    localparam int TXP_SPAN_W     = 12;
    localparam int TXP_BYTES      = 4;
    localparam int TXP_SPACE_W    = 16;
    localparam int TXP_CNT_W      = 8;
    // end alignment codes and masks
    localparam logic [1:0] TXP_ALN_4   = 2'h0;
    localparam logic [1:0] TXP_ALN_16  = 2'h1;
    localparam logic [1:0] TXP_ALN_32  = 2'h2;
    localparam logic [1:0] TXP_ALN_RSV = 2'h3;
    localparam logic [11:0] TXP_MASK_4  = 12'h003;
    localparam logic [11:0] TXP_MASK_16 = 12'h00F;
    localparam logic [11:0] TXP_MASK_32 = 12'h01F;
    // status word: tag, error, byte count
    localparam int TXP_S_ERR      = 15;
    localparam logic [3:0] TXP_S_ZERO = 4'h0;
    // host needs room for one whole word before writing
    localparam logic [15:0] TXP_WORD_ROOM = 16'h0004;

    typedef enum logic [1:0] {TXP_CMD_A, TXP_CMD_B, TXP_DATA} txp_phase_type;
    typedef enum logic [1:0] {TXP_H_IDLE, TXP_H_WAIT, TXP_H_HI} txp_hphase_type;
endpackage : txp_pkg

// *** src/txp_if.sv ***
/*
 * interface joining the host end and the device end.
 * assumes both ends share mclk; the bench joins the modports.
 */
interface txp_if;
    import txp_pkg::*;
    // host to device
    logic                   wr_en;
    logic [15:0]            wr_half;
    logic                   err_clr;
    logic                   done_clr;
    logic                   sts_rd;
    logic [TXP_CNT_W-1:0]   sts_level;
    // device to host
    logic [TXP_SPACE_W-1:0] tx_fifo_space_info;
    logic                   tx_error_flag;
    logic                   buffer_loaded_flag;
    logic [31:0]            sts_word;
    logic [TXP_CNT_W-1:0]   sts_count;
    logic                   sts_level_irq;

    modport dev (input wr_en, wr_half, err_clr, done_clr, sts_rd, sts_level,
                 output tx_fifo_space_info, tx_error_flag,
                 buffer_loaded_flag, sts_word, sts_count, sts_level_irq);
    modport host (output wr_en, wr_half, err_clr, done_clr, sts_rd,
                  sts_level,
                  input tx_fifo_space_info, tx_error_flag,
                  buffer_loaded_flag, sts_word, sts_count, sts_level_irq);
endinterface : txp_if

// *** src/txp_dev.sv ***
/*
 * device end: pairs host halves into words, parses per-buffer commands,
 * strips offset and padding bytes, checks commands and lengths, stores
 * payload bytes, sends them out one byte at a time and posts status.
 * assumes a byte sink with valid/ready on the user side.
 */
module txp_dev
    import txp_pkg::*;
#(
    parameter int DEPTH_LOG = 11,
    parameter int STS_LOG   = 4
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // host side
    txp_if.dev              bus,
    // byte sink
    output logic            out_valid,
    output logic [7:0]      out_byte,
    output logic            out_last,
    input  wire logic       out_ready
);
    localparam int DEPTH = 1 << DEPTH_LOG;
    localparam int SDEP  = 1 << STS_LOG;
    localparam int EW    = TXP_TAG_W + 10;

    if (DEPTH_LOG < 6 || DEPTH_LOG > 15 || STS_LOG < 1 || STS_LOG > 7) begin : g_bad
        $error("txp_dev: depth parameters out of range");
    end

    typedef struct packed {
        txp_phase_type          phase;
        logic                   half_ph;
        logic [15:0]            half_lo;
        logic [31:0]            cmd_a;
        logic [31:0]            cmd_b;
        logic                   pkt_err;
        logic [TXP_LEN_W-1:0]   byte_cnt;
        logic [TXP_SPAN_W-1:0]  word_base;
        logic [9:0]             words_left;
        logic [DEPTH_LOG:0]     wr_ptr;
        logic [DEPTH_LOG:0]     rd_ptr;
        logic                   out_valid;
        logic [7:0]             out_byte;
        logic                   out_last;
        logic [TXP_TAG_W-1:0]   out_tag;
        logic                   out_err;
        logic [TXP_LEN_W-1:0]   tx_cnt;
        logic [STS_LOG:0]       s_wr;
        logic [STS_LOG:0]       s_rd;
        logic [31:0]            sts_word;
        logic [TXP_SPACE_W-1:0] space;
        logic                   err_flag;
        logic                   done_flag;
        logic                   irq;
        logic [TXP_CNT_W-1:0]   s_cnt;
    } txp_dev_type;

    txp_dev_type st_r, st_nxt;
    logic [EW-1:0]  mem [DEPTH];
    logic [31:0]    smem [SDEP];

    logic [TXP_BYTES-1:0]   wen;
    logic [DEPTH_LOG-1:0]   waddr [TXP_BYTES];
    logic [EW-1:0]          wdat [TXP_BYTES];
    logic                   s_push;
    logic [31:0]            s_push_word;

    logic [31:0]            word;
    logic [TXP_SPAN_W-1:0]  off, bend, pos, rnd, span_mask;
    logic [TXP_LEN_W-1:0]   pkt_len, got;
    logic [2:0]             nval, rank;
    logic [TXP_BYTES-1:0]   vb;
    logic [DEPTH_LOG:0]     used;
    logic                   err_set, done_set, last_err, word_done;
    logic [STS_LOG:0]       s_used;

    always_comb begin
        st_nxt      = st_r;
        wen         = '0;
        s_push      = 1'b0;
        s_push_word = '0;
        err_set     = 1'b0;
        done_set    = 1'b0;
        last_err    = 1'b0;
        word_done   = 1'b0;
        nval        = '0;
        rank        = '0;
        vb          = '0;
        pos         = '0;
        got         = '0;
        word        = {bus.wr_half, st_r.half_lo};
        for (int k = 0; k < TXP_BYTES; k++) begin
            waddr[k] = '0;
            wdat[k]  = '0;
        end
        off  = TXP_SPAN_W'(st_r.cmd_a[TXP_A_OFF_HI:TXP_A_OFF_LO]);
        bend = off + TXP_SPAN_W'(st_r.cmd_a[TXP_A_SIZE_HI:0]);
        pkt_len = st_r.cmd_b[TXP_B_LEN_HI:0];
        case (st_r.cmd_a[TXP_A_ALN_HI:TXP_A_ALN_LO])  // see RULE_18
            TXP_ALN_16: span_mask = TXP_MASK_16;
            TXP_ALN_32: span_mask = TXP_MASK_32;
            default:    span_mask = TXP_MASK_4;
        endcase
        rnd = (bend + span_mask) & ~span_mask;      // see RULE_10

        // low half first, high half completes the word
        if (bus.wr_en) begin                        // see RULE_16
            st_nxt.half_ph = ~st_r.half_ph;
            if (!st_r.half_ph)
                st_nxt.half_lo = bus.wr_half;
        end
        word_done = bus.wr_en && st_r.half_ph;

        used = st_r.wr_ptr - st_r.rd_ptr;
        if (word_done) begin
            case (st_r.phase)
                TXP_CMD_A: begin                    // see RULE_01
                    st_nxt.cmd_a = word;
                    st_nxt.phase = TXP_CMD_B;
                    // a new packet starts with a clean error state
                    if (word[TXP_A_FIRST])
                        st_nxt.pkt_err = 1'b0;      // see RULE_03
                    if (word[TXP_A_ALN_HI:TXP_A_ALN_LO] == TXP_ALN_RSV) begin
                        err_set        = 1'b1;      // see RULE_21
                        st_nxt.pkt_err = 1'b1;
                    end
                end
                TXP_CMD_B: begin                    // see RULE_04
                    st_nxt.cmd_b      = word;
                    st_nxt.word_base  = '0;
                    st_nxt.words_left = rnd[TXP_SPAN_W-1:2];
                    st_nxt.phase      = (rnd == '0) ? TXP_CMD_A : TXP_DATA;
                    if (st_r.cmd_a[TXP_A_FIRST]) begin  // see RULE_03
                        st_nxt.cmd_b    = word;     // see RULE_20
                        st_nxt.byte_cnt = '0;
                    end else begin
                        st_nxt.cmd_b = st_r.cmd_b;
                        if (word != st_r.cmd_b) begin
                            err_set        = 1'b1;  // see RULE_06
                            st_nxt.pkt_err = 1'b1;
                        end
                    end
                    if (rnd == '0 && st_r.cmd_a[TXP_A_IOC])
                        done_set = 1'b1;
                end
                default: begin
                    for (int k = 0; k < TXP_BYTES; k++) begin
                        pos   = st_r.word_base + TXP_SPAN_W'(k);
                        vb[k] = (pos >= off) && (pos < bend);  // see RULE_08
                        nval  = nval + 3'(vb[k]);
                    end
                    got = st_r.byte_cnt + TXP_LEN_W'(nval);
                    if (st_r.cmd_a[TXP_A_LAST] && got != pkt_len
                            && bend > st_r.word_base
                            && bend <= st_r.word_base + TXP_SPAN_W'(4))
                        last_err = 1'b1;            // see RULE_07
                    if (TXP_SPACE_W'(nval) > st_r.space) begin
                        err_set = 1'b1;             // see RULE_15
                    end else begin
                        for (int k = 0; k < TXP_BYTES; k++) begin
                            pos = st_r.word_base + TXP_SPAN_W'(k);
                            if (vb[k]) begin        // see RULE_09
                                wen[k]   = 1'b1;
                                waddr[k] = st_r.wr_ptr[DEPTH_LOG-1:0]
                                    + DEPTH_LOG'(rank);
                                wdat[k]  = {st_r.cmd_b[TXP_B_TAG_HI:
                                    TXP_B_TAG_LO],
                                    st_r.pkt_err | last_err,
                                    st_r.cmd_a[TXP_A_LAST]
                                        && pos == bend - 12'h001,
                                    word[8*k +: 8]};
                                rank = rank + 3'h1;
                            end
                        end
                        st_nxt.wr_ptr   = st_r.wr_ptr + (DEPTH_LOG+1)'(nval);
                        st_nxt.byte_cnt = got;
                    end
                    err_set = err_set | last_err;
                    st_nxt.word_base  = st_r.word_base + 12'h004;
                    st_nxt.words_left = st_r.words_left - 10'h001;
                    if (st_r.words_left == 10'h001) begin
                        st_nxt.phase = TXP_CMD_A;
                        if (st_r.cmd_a[TXP_A_IOC])
                            done_set = 1'b1;        // see RULE_11
                    end
                end
            endcase
        end

        // byte sink side
        if (st_r.out_valid && out_ready) begin
            st_nxt.out_valid = 1'b0;
            st_nxt.tx_cnt    = st_r.tx_cnt + 11'h001;
            if (st_r.out_last) begin                // see RULE_12
                st_nxt.tx_cnt = '0;
                s_push        = (st_r.s_wr - st_r.s_rd) != (STS_LOG+1)'(SDEP);
                s_push_word   = {st_r.out_tag, st_r.out_err, TXP_S_ZERO,
                                 st_r.tx_cnt + 11'h001};  // see RULE_05
            end
        end
        if ((!st_r.out_valid || out_ready) && used != '0) begin
            {st_nxt.out_tag, st_nxt.out_err, st_nxt.out_last,
             st_nxt.out_byte} = mem[st_r.rd_ptr[DEPTH_LOG-1:0]];
            st_nxt.out_valid = 1'b1;
            st_nxt.rd_ptr    = st_r.rd_ptr + 1'b1;
        end
        st_nxt.space = TXP_SPACE_W'(DEPTH)
            - TXP_SPACE_W'(st_nxt.wr_ptr - st_nxt.rd_ptr);

        // status fifo
        if (s_push)
            st_nxt.s_wr = st_r.s_wr + 1'b1;
        if (bus.sts_rd && st_r.s_wr != st_r.s_rd)
            st_nxt.s_rd = st_r.s_rd + 1'b1;
        if (s_push && st_r.s_wr == st_nxt.s_rd)
            st_nxt.sts_word = s_push_word;
        else
            st_nxt.sts_word = smem[st_nxt.s_rd[STS_LOG-1:0]];
        s_used = st_nxt.s_wr - st_nxt.s_rd;
        st_nxt.s_cnt = TXP_CNT_W'(s_used);
        st_nxt.irq = bus.sts_level != '0
            && TXP_CNT_W'(s_used) >= bus.sts_level;  // see RULE_13

        // sticky flags: a set in the clear cycle wins
        st_nxt.err_flag  = err_set || (st_r.err_flag && !bus.err_clr);
        st_nxt.done_flag = done_set                 // see RULE_17
            || (st_r.done_flag && !bus.done_clr);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.phase   <= TXP_CMD_A;
            st_r.space   <= TXP_SPACE_W'(DEPTH);
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        for (int k = 0; k < TXP_BYTES; k++)
            if (wen[k])
                mem[waddr[k]] <= wdat[k];
        if (s_push)
            smem[st_r.s_wr[STS_LOG-1:0]] <= s_push_word;
    end

    assign bus.tx_fifo_space_info = st_r.space;
    assign bus.tx_error_flag      = st_r.err_flag;
    assign bus.buffer_loaded_flag = st_r.done_flag;
    assign bus.sts_word           = st_r.sts_word;
    assign bus.sts_count          = st_r.s_cnt;
    assign bus.sts_level_irq      = st_r.irq;
    assign out_valid              = st_r.out_valid;
    assign out_byte               = st_r.out_byte;
    assign out_last               = st_r.out_last;
endmodule : txp_dev

// *** src/txp_host.sv ***
/*
 * host end: takes 32-bit words from its user, checks free space, and
 * writes each word as two 16-bit halves; relays status reads and flags.
 * assumes the user presents command A, command B, then payload words.
 */
module txp_host
    import txp_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // device side
    txp_if.host                       bus,
    // word stream from user
    input  wire logic                 usr_valid,
    input  wire logic [31:0]          usr_word,
    input  wire logic                 usr_is_cmd_a,
    output logic                      usr_ready,
    // control and status
    input  wire logic                 usr_err_clr,
    input  wire logic                 usr_done_clr,
    input  wire logic                 usr_sts_req,
    input  wire logic [TXP_CNT_W-1:0] usr_sts_level,
    output logic                      usr_sts_valid,
    output logic [31:0]               usr_sts_word,
    output logic                      usr_err,
    output logic                      usr_done,
    output logic                      usr_irq
);
    typedef struct packed {
        txp_hphase_type         phase;
        logic [31:0]            word;
        logic                   ready;
        logic                   wr_en;
        logic [15:0]            wr_half;
        logic                   err_clr;
        logic                   done_clr;
        logic                   sts_rd;
        logic [TXP_CNT_W-1:0]   level;
        logic                   sts_valid;
        logic [31:0]            sts_word;
        logic                   err;
        logic                   done;
        logic                   irq;
    } txp_host_type;

    txp_host_type h_r, h_nxt;

    always_comb begin
        h_nxt           = h_r;
        h_nxt.wr_en     = 1'b0;
        h_nxt.sts_valid = 1'b0;
        h_nxt.err_clr   = usr_err_clr;
        h_nxt.done_clr  = usr_done_clr;
        h_nxt.sts_rd    = usr_sts_req;
        h_nxt.level     = usr_sts_level;
        h_nxt.err       = bus.tx_error_flag;
        h_nxt.done      = bus.buffer_loaded_flag;
        h_nxt.irq       = bus.sts_level_irq;
        case (h_r.phase)
            TXP_H_IDLE: begin
                if (usr_valid) begin                // see RULE_02
                    h_nxt.word  = usr_word;
                    if (usr_is_cmd_a)
                        h_nxt.word[TXP_A_RSV_HI:TXP_A_RSV_LO] = '0;  // see RULE_19
                    h_nxt.ready = 1'b0;
                    h_nxt.phase = TXP_H_WAIT;
                end
            end
            TXP_H_WAIT: begin
                if (bus.tx_fifo_space_info >= TXP_WORD_ROOM) begin  // see RULE_14
                    h_nxt.wr_en   = 1'b1;
                    h_nxt.wr_half = h_r.word[15:0]; // see RULE_16
                    h_nxt.phase   = TXP_H_HI;
                end
            end
            default: begin
                h_nxt.wr_en   = 1'b1;
                h_nxt.wr_half = h_r.word[31:16];
                h_nxt.ready   = 1'b1;
                h_nxt.phase   = TXP_H_IDLE;
            end
        endcase
        if (h_r.sts_rd && bus.sts_count != '0) begin
            h_nxt.sts_valid = 1'b1;
            h_nxt.sts_word  = bus.sts_word;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            h_r       <= '0;
            h_r.phase <= TXP_H_IDLE;
            h_r.ready <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign usr_ready     = h_r.ready;
    assign usr_sts_valid = h_r.sts_valid;
    assign usr_sts_word  = h_r.sts_word;
    assign usr_err       = h_r.err;
    assign usr_done      = h_r.done;
    assign usr_irq       = h_r.irq;
    assign bus.wr_en     = h_r.wr_en;
    assign bus.wr_half   = h_r.wr_half;
    assign bus.err_clr   = h_r.err_clr;
    assign bus.done_clr  = h_r.done_clr;
    assign bus.sts_rd    = h_r.sts_rd;
    assign bus.sts_level = h_r.level;
endmodule : txp_host

// *** testbench/txp_asserts.sv ***
/* txp_asserts: checks on the host/device interface wires.
   assumes one clock mclk and async active-low rst_n. */
module txp_asserts #(parameter int DEPTH = 2048) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // interface wires
    input wire logic        wr_en,
    input wire logic        err_clr,
    input wire logic        done_clr,
    input wire logic        sts_rd,
    input wire logic [7:0]  sts_level,
    input wire logic [15:0] tx_fifo_space_info,
    input wire logic        tx_error_flag,
    input wire logic        buffer_loaded_flag,
    input wire logic [7:0]  sts_count,
    input wire logic        sts_level_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_pair; wr_en ##1 wr_en ##1 !wr_en; endsequence
    sequence s_after_wr; $past(wr_en) || $past(wr_en, 2); endsequence
    property p_pair; $rose(wr_en) |-> s_pair; endproperty
    property p_err_hold; tx_error_flag && !err_clr |=> tx_error_flag;
    endproperty
    property p_done_hold; buffer_loaded_flag && !done_clr |=>
        buffer_loaded_flag; endproperty
    property p_err_clr; err_clr && !wr_en && !$past(wr_en) |=>
        !tx_error_flag; endproperty
    property p_done_clr; done_clr && !wr_en && !$past(wr_en) |=>
        !buffer_loaded_flag; endproperty
    property p_err_src; $rose(tx_error_flag) |-> s_after_wr; endproperty
    property p_done_src; $rose(buffer_loaded_flag) |-> s_after_wr;
    endproperty
    property p_irq; 1'b1 |=> sts_level_irq == ($past(sts_level) != 8'h00
        && sts_count >= $past(sts_level)); endproperty
    property p_space; tx_fifo_space_info <= DEPTH; endproperty
    property p_empty_rd; sts_rd && sts_count == 8'h00 |=> sts_count <= 8'h01;
    endproperty
    a_pair: assert property (p_pair) else $error("halves not paired");
    a_err_hold: assert property (p_err_hold) else $error("error lost");
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    a_err_clr: assert property (p_err_clr) else $error("error kept");
    a_done_clr: assert property (p_done_clr) else $error("done kept");
    a_err_src: assert property (p_err_src) else $error("stray error");
    a_done_src: assert property (p_done_src) else $error("stray done");
    a_irq: assert property (p_irq) else $error("level irq wrong");
    a_space: assert property (p_space) else $error("space too big");
    a_empty_rd: assert property (p_empty_rd) else $error("empty pop");
endmodule : txp_asserts

// *** testbench/testbench.sv ***
/* testbench: host end joined to device end, driven from the user sides.
   assumes the interface, package and both ends are compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import txp_pkg::*;
    logic mclk = 0, rst_n = 0, usr_valid = 0, usr_is_cmd_a = 0, out_ready = 0;
    logic [31:0] usr_word = 0;
    logic usr_err_clr = 0, usr_done_clr = 0, usr_sts_req = 0;
    logic [7:0] usr_sts_level = 8'h01;
    logic usr_ready, usr_sts_valid, usr_err, usr_done, usr_irq;
    logic out_valid, out_last;
    logic [7:0] out_byte;
    logic [31:0] usr_sts_word;
    logic [7:0] exp_q[$], got_q[$];
    int miscompares = 0, num_checks = 0;
    txp_if bus();
    txp_host txp_host_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus),
        .usr_valid(usr_valid), .usr_word(usr_word),
        .usr_is_cmd_a(usr_is_cmd_a), .usr_ready(usr_ready),
        .usr_err_clr(usr_err_clr), .usr_done_clr(usr_done_clr),
        .usr_sts_req(usr_sts_req), .usr_sts_level(usr_sts_level),
        .usr_sts_valid(usr_sts_valid), .usr_sts_word(usr_sts_word),
        .usr_err(usr_err), .usr_done(usr_done), .usr_irq(usr_irq));
    txp_dev #(.DEPTH_LOG(6), .STS_LOG(2)) txp_dev_inst (.mclk(mclk),
        .rst_n(rst_n), .bus(bus), .out_valid(out_valid),
        .out_byte(out_byte), .out_last(out_last), .out_ready(out_ready));
    txp_asserts #(.DEPTH(64)) txp_asserts_inst (.mclk(mclk), .rst_n(rst_n),
        .wr_en(bus.wr_en), .err_clr(bus.err_clr), .done_clr(bus.done_clr),
        .sts_rd(bus.sts_rd), .sts_level(bus.sts_level),
        .tx_fifo_space_info(bus.tx_fifo_space_info),
        .tx_error_flag(bus.tx_error_flag),
        .buffer_loaded_flag(bus.buffer_loaded_flag),
        .sts_count(bus.sts_count), .sts_level_irq(bus.sts_level_irq));
    always #4 mclk = ~mclk;
    // sink stalls every other cycle
    always @(posedge mclk) #1 out_ready = ~out_ready;
    always @(posedge mclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(out_byte);
    end
    task automatic close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic put(input logic [31:0] w, input logic a);
        int n;
        n = 0;
        while (usr_ready !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        usr_valid = 1;
        usr_word = w;
        usr_is_cmd_a = a;
        step(1);
        usr_valid = 0;
    endtask : put
    // bytes before offset and pad bytes are marked so leaks show
    task automatic send_buf(input logic ioc, input logic [1:0] aln,
        input int off, input logic fs, input logic ls, input int size,
        input logic [31:0] wb, input logic [7:0] seed);
        logic [31:0] w;
        logic [7:0] b;
        int al, nb;
        al = (aln == TXP_ALN_16) ? 16 : (aln == TXP_ALN_32) ? 32 : 4;
        nb = ((off + size + al - 1) / al) * al;
        w = {ioc, 5'h00, aln, 3'h0, 5'(off), 2'h0, fs, ls, 1'b0, 11'(size)};
        put(w, 1'b1);
        put(wb, 1'b0);
        for (int k = 0; k < nb; k++) begin
            b = (k < off) ? 8'hEE : (k < off + size) ? 8'(seed + k - off) : 8'hDD;
            if (k >= off && k < off + size) exp_q.push_back(b);
            w[8*(k%4) +: 8] = b;
            if (k % 4 == 3) put(w, 1'b0);
        end
    endtask : send_buf
    task automatic get_sts(input logic [31:0] exp, input logic [31:0] mask);
        int n;
        n = 0;
        while (usr_irq !== 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        chk(usr_irq, 1);
        usr_sts_req = 1;
        step(1);
        usr_sts_req = 0;
        n = 0;
        while (usr_sts_valid !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk(usr_sts_word & mask, exp);
        step(3);
    endtask : get_sts
    task automatic cmp_bytes;
        chk(32'(got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        got_q.delete();
        exp_q.delete();
    endtask : cmp_bytes
    task automatic clr;
        usr_err_clr = 1;
        usr_done_clr = 1;
        step(1);
        usr_err_clr = 0;
        usr_done_clr = 0;
        step(4);
    endtask : clr
    task automatic err_pkt(input logic [15:0] tag);
        get_sts({tag, 16'h8000}, 32'hFFFF8000);
        chk(usr_err, 1);
        got_q.delete();
        exp_q.delete();
        clr();
    endtask : err_pkt
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end
    initial begin
        step(10);
        rst_n = 1;
        step(1);
        send_buf(1, TXP_ALN_16, 3, 1, 1, 5, 32'h12340005, 8'h10);
        get_sts(32'h12340005, 32'hFFFFFFFF);
        cmp_bytes();
        chk(usr_done, 1);
        chk(usr_err, 0);
        clr();
        send_buf(0, TXP_ALN_32, 0, 1, 0, 3, 32'h55AA0007, 8'h20);
        send_buf(0, TXP_ALN_4, 2, 0, 1, 4, 32'h55AA0007, 8'h23);
        get_sts(32'h55AA0007, 32'hFFFFFFFF);
        cmp_bytes();
        chk(usr_done, 0);
        chk(usr_err, 0);
        send_buf(0, TXP_ALN_4, 0, 1, 0, 2, 32'h0BAD0004, 8'h30);
        send_buf(0, TXP_ALN_4, 0, 0, 1, 2, 32'h0BAE0004, 8'h32);
        err_pkt(16'h0BAD);
        send_buf(0, TXP_ALN_4, 1, 1, 1, 4, 32'h0C0C0006, 8'h40);
        err_pkt(16'h0C0C);
        send_buf(0, TXP_ALN_RSV, 0, 1, 1, 4, 32'h0D0D0004, 8'h50);
        err_pkt(16'h0D0D);
        // a clean packet after errored ones must report no error
        send_buf(1, TXP_ALN_4, 0, 1, 1, 4, 32'h0E0E0004, 8'h60);
        get_sts(32'h0E0E0004, 32'hFFFFFFFF);
        cmp_bytes();
        chk(usr_done, 1);
        close_out();
    end
endmodule : testbench
